// ### src/branch_pkg.sv
// Shared constants and types of the conditional branch unit
package branch_pkg;

  localparam int INSTR_W = 24;
  localparam int PC_W    = 24;

  // Upper byte of the instruction word selects the branch kind
  localparam logic [7:0] OP_UNSIGNED_LT = 8'h39;
  localparam logic [7:0] OP_NEGATIVE    = 8'h33;
  localparam logic [7:0] OP_NOT_NEG     = 8'h3B;
  localparam logic [7:0] OP_NO_OVF      = 8'h38;
  localparam logic [7:0] OP_NOT_ZERO    = 8'h3A;
  localparam logic [7:0] OP_ACC_A_OVF   = 8'h0C;
  localparam logic [7:0] OP_ACC_B_OVF   = 8'h0D;

  // Program words are two address units apart
  localparam logic [PC_W-1:0] PC_STEP = 24'h00_0002;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STAT_OFS   = 12'h004;
  localparam logic [11:0] COUNT_OFS  = 12'h008;
  localparam logic [11:0] TARGET_OFS = 12'h00C;

  // Control fields and reset value
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_TAKEN_BIT = 1;

  localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [PC_W-1:0] PC_RESET = 24'h00_0000;

  typedef struct packed {
    logic carry;
    logic negative;
    logic overflow;
    logic zero;
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
  } flags_t;

  typedef struct packed {
    logic [INSTR_W-1:0] instr;
    logic [PC_W-1:0]    pc;
    flags_t             status_register;
  } branch_req_t;

  typedef struct packed {
    logic            taken;
    logic            is_branch;
    logic [PC_W-1:0] pc;
  } pc_update_t;

endpackage

// ### src/conditional_branch_unit.sv
// Conditional branch decode and execute with an APB control port
// How it works
// [RQ1] A taken branch loads the PC with PC plus 2 plus twice the signed offset.
// [RQ2] A taken branch takes two cycles and forces a NOP into the instruction register in the second.
// [RQ3] An untaken branch finishes in one cycle and flow continues sequentially; a taken one in two.
// [RQ4] The offset is a two's complement 16-bit count of instruction words from PC plus 2.
// [RQ5] Opcode 0011 1001 branches when carry is clear, the same encoding as branch-if-not-carry.
// [RQ6] Opcode 0011 0011 branches only when the negative flag is 1.
// [RQ7] Opcode 0011 1011 branches only when the negative flag is 0.
// [RQ8] Opcode 0011 1000 branches only when the overflow flag is 0.
// [RQ9] Opcode 0011 1010 branches only when the zero flag is 0.
// [RQ10] Opcode 0000 1100 branches only when the accumulator A overflow flag is set.
// [RQ11] Opcode 0000 1101 branches only when the accumulator B overflow flag is set.
// [RQ12] The low 16 bits of the single instruction word carry the offset.
// [RQ13] No status flag is changed by these branches, taken or not.
// [RQ14] Sequential flow steps the PC by 2 and every branch target is word aligned.
//
// Our own choices: the register offsets and register access over APB.
module conditional_branch_unit (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire branch_pkg::branch_req_t req,
  output branch_pkg::pc_update_t     pc_update,
  output logic                       pc_update_valid,
  output logic                       nop_insert,
  output branch_pkg::flags_t         status_register_out,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);

  typedef enum logic [0:0] {
    EXEC,
    NOP_SLOT
  } state_t;

  state_t                      state_r;
  logic [31:0]                 ctrl_r;
  logic [31:0]                 count_r;
  logic [branch_pkg::PC_W-1:0] target_r;
  logic                        last_taken_r;
  logic [31:0]                 prdata_r;
  branch_pkg::pc_update_t      pc_update_r;
  logic                        pc_update_valid_r;
  branch_pkg::flags_t          status_r;

  logic                        accept;
  logic                        is_branch;
  logic                        cond_true;
  logic                        taken;
  logic [branch_pkg::PC_W-1:0] seq_pc;
  logic [branch_pkg::PC_W-1:0] branch_pc;
  logic                        setup;
  logic                        access;
  logic                        mapped;

  // Condition for each opcode; unknown opcodes are not branches
  function automatic logic [1:0] decode(input logic [7:0] op, input branch_pkg::flags_t f);
    logic [1:0] r;
    r = 2'b00;
    case (op)
      branch_pkg::OP_UNSIGNED_LT: r = {1'b1, ~f.carry};               // see [RQ5]
      branch_pkg::OP_NEGATIVE:    r = {1'b1, f.negative};             // see [RQ6]
      branch_pkg::OP_NOT_NEG:     r = {1'b1, ~f.negative};            // see [RQ7]
      branch_pkg::OP_NO_OVF:      r = {1'b1, ~f.overflow};            // see [RQ8]
      branch_pkg::OP_NOT_ZERO:    r = {1'b1, ~f.zero};                // see [RQ9]
      branch_pkg::OP_ACC_A_OVF:   r = {1'b1, f.acc_a_overflow_flag};  // see [RQ10]
      branch_pkg::OP_ACC_B_OVF:   r = {1'b1, f.acc_b_overflow_flag};  // see [RQ11]
      default:                    r = 2'b00;
    endcase
    return r;
  endfunction

  // Word-aligned PC plus a signed word offset
  function automatic logic [branch_pkg::PC_W-1:0] add_words(
    input logic [branch_pkg::PC_W-1:0] base,
    input logic [15:0]                 words
  );
    logic [branch_pkg::PC_W-1:0] ofs;
    ofs = {{(branch_pkg::PC_W-17){words[15]}}, words, 1'b0};          // see [RQ4]
    return {base[branch_pkg::PC_W-1:1] + ofs[branch_pkg::PC_W-1:1], 1'b0}; // see [RQ14]
  endfunction

  // Branch execution

  // No new instruction is taken during the NOP slot
  assign req_ready = (state_r == EXEC);                               // see [RQ3]
  assign accept    = req_valid && req_ready;
  assign is_branch = decode(req.instr[23:16], req.status_register)[1];
  assign cond_true = decode(req.instr[23:16], req.status_register)[0];
  // Disabled unit lets every branch fall through
  assign taken     = is_branch && cond_true && ctrl_r[branch_pkg::CTRL_ENABLE_BIT];

  assign seq_pc    = add_words(req.pc, 16'h0000) + branch_pkg::PC_STEP; // see [RQ14]
  // Offset sits in the low 16 bits of the one instruction word
  assign branch_pc = add_words(seq_pc, req.instr[15:0]);              // see [RQ1] [RQ12]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= EXEC;
    end else begin
      case (state_r)
        EXEC: begin
          if (accept && taken) begin
            state_r <= NOP_SLOT;                                      // see [RQ2]
          end
        end
        NOP_SLOT: begin
          state_r <= EXEC;                                            // see [RQ3]
        end
        default: begin
          state_r <= EXEC;
        end
      endcase
    end
  end

  // Prefetched word is squashed in the second cycle
  assign nop_insert = (state_r == NOP_SLOT);                          // see [RQ2]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_update_r       <= '0;
      pc_update_valid_r <= 1'b0;
    end else begin
      pc_update_valid_r <= accept;
      if (accept) begin
        pc_update_r.taken     <= taken;
        pc_update_r.is_branch <= is_branch;
        pc_update_r.pc        <= taken ? branch_pc : seq_pc;          // see [RQ1] [RQ3]
      end
    end
  end

  assign pc_update       = pc_update_r;
  assign pc_update_valid = pc_update_valid_r;

  // Flags are only carried through, never written here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= '0;
    end else if (accept) begin
      status_r <= req.status_register;                                // see [RQ13]
    end
  end

  assign status_register_out = status_r;

  // Statistics

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= branch_pkg::COUNT_RESET;
    end else if (accept && taken) begin
      // A taken branch in the clearing cycle still counts
      if (access && pwrite && paddr == branch_pkg::CTRL_OFS && pwdata[branch_pkg::CTRL_CLEAR_BIT]) begin
        count_r <= 32'h0000_0001;
      end else begin
        count_r <= count_r + 32'h0000_0001;
      end
    end else if (access && pwrite && paddr == branch_pkg::CTRL_OFS
                 && pwdata[branch_pkg::CTRL_CLEAR_BIT]) begin
      count_r <= branch_pkg::COUNT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_r     <= branch_pkg::PC_RESET;
      last_taken_r <= 1'b0;
    end else if (accept && is_branch) begin
      last_taken_r <= taken;
      if (taken) begin
        target_r <= branch_pc;
      end
    end
  end

  // APB slave, one wait-free access cycle

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == branch_pkg::CTRL_OFS) || (paddr == branch_pkg::STAT_OFS)
               || (paddr == branch_pkg::COUNT_OFS) || (paddr == branch_pkg::TARGET_OFS);

  assign pready  = access;
  assign pslverr = access && !mapped;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= branch_pkg::CTRL_RESET;
    end else if (access && pwrite && paddr == branch_pkg::CTRL_OFS) begin
      // Clear bit is a write pulse and is not stored
      ctrl_r <= {31'h0000_0000, pwdata[branch_pkg::CTRL_ENABLE_BIT]};
    end
  end

  // Read data is captured in the setup cycle so it comes from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        branch_pkg::CTRL_OFS:   prdata_r <= ctrl_r;
        branch_pkg::STAT_OFS:   prdata_r <= {30'h0000_0000, last_taken_r,
                                             state_r == NOP_SLOT};
        branch_pkg::COUNT_OFS:  prdata_r <= count_r;
        branch_pkg::TARGET_OFS: prdata_r <= {8'h00, target_r};
        default:                prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_r;

endmodule

// ### testbench/conditional_branch_unit_chk.sv
// Port checker for the conditional branch unit
module conditional_branch_unit_chk (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    req_valid,
  input wire logic                    req_ready,
  input wire branch_pkg::branch_req_t req,
  input wire branch_pkg::pc_update_t  pc_update,
  input wire logic                    pc_update_valid,
  input wire logic                    nop_insert,
  input wire branch_pkg::flags_t      status_register_out,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic logic cond(input branch_pkg::flags_t f, input logic [7:0] op);
    case (op)
      branch_pkg::OP_UNSIGNED_LT: cond = !f.carry;
      branch_pkg::OP_NEGATIVE:    cond = f.negative;
      branch_pkg::OP_NOT_NEG:     cond = !f.negative;
      branch_pkg::OP_NO_OVF:      cond = !f.overflow;
      branch_pkg::OP_NOT_ZERO:    cond = !f.zero;
      branch_pkg::OP_ACC_A_OVF:   cond = f.acc_a_overflow_flag;
      branch_pkg::OP_ACC_B_OVF:   cond = f.acc_b_overflow_flag;
      default:                    cond = 1'b0;
    endcase
  endfunction
  sequence s_taken;
    req_valid && req_ready ##1 pc_update_valid && pc_update.taken;
  endsequence
  a_nop_slot: assert property (s_taken |-> nop_insert && !req_ready ##1 !nop_insert && req_ready)
    else $error("nop slot wrong");
  a_answer_next: assert property (req_valid && req_ready |=> pc_update_valid)
    else $error("no answer");
  a_ready_nop: assert property (nop_insert |-> !req_ready)
    else $error("accept in nop slot");
  a_seq_step: assert property (pc_update_valid && !pc_update.taken |-> pc_update.pc == $past(req.pc) + branch_pkg::PC_STEP)
    else $error("sequential pc wrong");
  a_target_calc: assert property (pc_update_valid && pc_update.taken |-> pc_update.pc == $past(req.pc) + branch_pkg::PC_STEP + {{7{$past(req.instr[15])}}, $past(req.instr[15:0]), 1'b0})
    else $error("target wrong");
  a_word_align: assert property (pc_update_valid |-> !pc_update.pc[0])
    else $error("pc odd");
  a_flags_kept: assert property (pc_update_valid |-> status_register_out == $past(req.status_register))
    else $error("flags changed");
  a_taken_cond: assert property (pc_update_valid && pc_update.taken |-> cond($past(req.status_register), $past(req.instr[23:16])))
    else $error("taken on false condition");
  a_apb_nowait: assert property (psel && penable |-> pready)
    else $error("apb wait state");
endmodule

bind conditional_branch_unit conditional_branch_unit_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .pc_update(pc_update), .pc_update_valid(pc_update_valid), .nop_insert(nop_insert),
  .status_register_out(status_register_out), .psel(psel), .penable(penable), .pready(pready)
);

// ### testbench/conditional_branch_unit_test.sv
// Self-checking bench for the conditional branch unit
module conditional_branch_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, req_valid = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic req_ready, pc_update_valid, nop_insert, pready, pslverr, er;
  branch_pkg::branch_req_t req = '0;
  branch_pkg::pc_update_t pc_update;
  branch_pkg::flags_t status_register_out;
  int fails = 0, check_count = 0, ntaken = 0;
  logic [23:0] last_tgt = 24'h00_0000;
  logic [7:0] ops [7] = '{branch_pkg::OP_UNSIGNED_LT, branch_pkg::OP_NEGATIVE,
    branch_pkg::OP_NOT_NEG, branch_pkg::OP_NO_OVF, branch_pkg::OP_NOT_ZERO,
    branch_pkg::OP_ACC_A_OVF, branch_pkg::OP_ACC_B_OVF};
  // Lone flag that decides each kind, and whether a set flag takes it
  logic [5:0] masks [7] = '{6'h20, 6'h10, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  logic pols [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [15:0] offs [7] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001, 16'h0042, 16'hFFFE, 16'h0000};
  always #10 clk = ~clk;
  conditional_branch_unit u_dut (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .pc_update(pc_update), .pc_update_valid(pc_update_valid), .nop_insert(nop_insert),
    .status_register_out(status_register_out), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin @(negedge clk); if (pready === 1'b1) break; end
    if (n == 20) begin fails++; stop_test(); end
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic run(input logic [7:0] op, input logic [15:0] off, input logic [5:0] f,
                     input logic tk, input logic br);
    int n;
    logic [23:0] exp;
    exp = 24'h00_2000 + branch_pkg::PC_STEP + (tk ? {{7{off[15]}}, off, 1'b0} : 24'h00_0000);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {op, off, 24'h00_2000, f};
    for (n = 0; n < 20; n++) begin @(negedge clk); if (req_ready === 1'b1) break; end
    if (n == 20) begin fails++; stop_test(); end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    cmp(32'(pc_update_valid), 32'h0000_0001);
    cmp(32'(pc_update), 32'({tk, br, exp}));
    cmp(32'({nop_insert, req_ready}), 32'({tk, !tk}));
    cmp(32'(status_register_out), 32'(f));
    if (tk) begin ntaken++; last_tgt = exp; end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, branch_pkg::CTRL_OFS, 32'h0000_0000);
    cmp(rd, branch_pkg::CTRL_RESET);
    apb(1'b0, branch_pkg::COUNT_OFS, 32'h0000_0000);
    cmp(rd, branch_pkg::COUNT_RESET);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp({rd[30:0], er}, 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      run(ops[i], offs[i], masks[i], pols[i], 1'b1);
      run(ops[i], offs[i], ~masks[i], !pols[i], 1'b1);
    end
    run(8'h31, 16'h0010, 6'h3F, 1'b0, 1'b0);
    apb(1'b0, branch_pkg::COUNT_OFS, 32'h0000_0000);
    cmp(rd, 32'(ntaken));
    apb(1'b0, branch_pkg::TARGET_OFS, 32'h0000_0000);
    cmp(rd, 32'(last_tgt));
    apb(1'b1, branch_pkg::CTRL_OFS, 32'h0000_0000);
    run(branch_pkg::OP_NEGATIVE, 16'h0004, 6'h10, 1'b0, 1'b1);
    apb(1'b1, branch_pkg::CTRL_OFS, 32'h0000_0003);
    apb(1'b1, branch_pkg::COUNT_OFS, 32'h0000_0005);
    apb(1'b0, branch_pkg::COUNT_OFS, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    stop_test();
  end
endmodule
